// [logic/ascp_defines.svh]
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH

// Serial word sizes
`define ASCP_CFG_BITS      7
`define ASCP_RES_BITS      12
`define ASCP_CFG_LAST      3'h6
`define ASCP_RES_LAST      5'h0B
// Last index of the MSB-then-LSB sequence, shared LSB sent once
`define ASCP_SEQ_LAST      5'h16
`define ASCP_SEQ_END       5'h17
// Converter steps per conversion
`define ASCP_SAR_STEPS     4'hC
// Buffer depth and occupancy codes
`define ASCP_BUF_DEPTH     2
`define ASCP_BUF_EMPTY     2'h0
`define ASCP_BUF_ONE       2'h1
`define ASCP_BUF_FULL      2'h2
// Reset values
`define ASCP_RST_SHUTDOWN_N 1'b1
`define ASCP_RST_DOUT       1'b0
`define ASCP_RST_CFG        7'h01

`endif

// [logic/ascp_pkg.sv]
package ascp_pkg;

    typedef enum logic [5:0] {
        ASCP_IDLE  = 6'b000001,
        ASCP_HUNT  = 6'b000010,
        ASCP_CFG   = 6'b000100,
        ASCP_NULL  = 6'b001000,
        ASCP_DATA  = 6'b010000,
        ASCP_SPARE = 6'b100000
    } ascp_state_e;

    typedef struct packed {
        logic single_ended_select;
        logic pair_polarity;
        logic channel_index_hi;
        logic channel_index_lo;
        logic unipolar_select;
        logic bit_order_select;
        logic power_down_n;
    } ascp_cfg_s;

    typedef struct packed {
        logic [2:0] pos_channel;
        logic [2:0] neg_channel;
        logic       neg_is_common;
    } ascp_mux_s;

    typedef struct packed {
        ascp_mux_s mux;
        logic      unipolar_select;
    } ascp_conv_cfg_s;

    typedef struct packed {
        logic sclk_rise;
        logic sclk_fall;
        logic cs_fall;
        logic cs_rise;
        logic din;
        logic cs_low;
    } ascp_edges_s;

endpackage

// [logic/ascp_edge.sv]
`timescale 1ns/10ps
`include "ascp_defines.svh"

module ascp_edge
    import ascp_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rstn,
    input  wire logic  cs_n,
    input  wire logic  sclk,
    input  wire logic  din,
    output ascp_edges_s edges
);

    typedef struct packed {
        logic        sclk_q;
        logic        cs_n_q;
        ascp_edges_s ev;
    } ascp_edge_state_s;

    ascp_edge_state_s state;
    ascp_edge_state_s next_state;

    // Edge pulses aligned with the data bit sampled at the same edge
    always_comb begin
        next_state              = state;
        next_state.sclk_q       = sclk;
        next_state.cs_n_q       = cs_n;
        next_state.ev.sclk_rise = sclk & ~state.sclk_q;
        next_state.ev.sclk_fall = ~sclk & state.sclk_q;
        next_state.ev.cs_fall   = ~cs_n & state.cs_n_q;
        next_state.ev.cs_rise   = cs_n & ~state.cs_n_q;
        next_state.ev.din       = din;
        next_state.ev.cs_low    = ~cs_n;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= '{sclk_q: 1'b0, cs_n_q: 1'b1, ev: '0};
        end else begin
            state <= next_state;
        end
    end

    assign edges = state.ev;

endmodule // ascp_edge

// [logic/ascp_buf.sv]
`timescale 1ns/10ps
`include "ascp_defines.svh"

module ascp_buf
    import ascp_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      flush,
    input  wire logic                      in_valid,
    output logic                           in_ready,
    input  wire logic [`ASCP_RES_BITS-1:0] in_data,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic [`ASCP_RES_BITS-1:0]      out_data
);

    typedef struct packed {
        logic [`ASCP_BUF_DEPTH-1:0][`ASCP_RES_BITS-1:0] mem;
        logic                                          wr_idx;
        logic                                          rd_idx;
        logic [1:0]                                    cnt;
        logic                                          ready;
    } ascp_buf_state_s;

    ascp_buf_state_s state;
    ascp_buf_state_s next_state;
    logic            push;
    logic            pop;

    assign in_ready  = state.ready;
    assign out_valid = (state.cnt != `ASCP_BUF_EMPTY);
    assign out_data  = state.mem[state.rd_idx];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_state = state;
        if (flush) begin
            next_state.cnt    = `ASCP_BUF_EMPTY;
            next_state.wr_idx = 1'b0;
            next_state.rd_idx = 1'b0;
        end else begin
            if (push) begin
                next_state.mem[state.wr_idx] = in_data;
                next_state.wr_idx            = ~state.wr_idx;
            end
            if (pop) begin
                next_state.rd_idx = ~state.rd_idx;
            end
            if (push && !pop) begin
                next_state.cnt = state.cnt + `ASCP_BUF_ONE;
            end else if (pop && !push) begin
                next_state.cnt = state.cnt - `ASCP_BUF_ONE;
            end
        end
        next_state.ready = (next_state.cnt != `ASCP_BUF_FULL);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state       <= '0;
            state.ready <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

endmodule // ascp_buf

// [logic/ascp_port.sv]
// Behaviour
// - Drive on falling, sample on rising clock
// - Config word in first, result out after
// - Chip select low starts start-bit search
// - First sampled one is start bit
// - Take seven config bits, then start conversion unless the power-down bit is clear
// - Ignore input after config until next select
// - One null bit, then result out; code sends null bits until the result is in
// - Result belongs to this transaction only
// - Chip select high resets serial state
// - Twelve-bit result, serial clock paces conversion
// - First four bits set the multiplexer
// - Differential pair 2k/2k+1, polarity bit orders
// - Single-ended channel 2k plus polarity versus common
// - Unipolar when set, bipolar when clear
// - MSB first, then zeros or LSB-first repeat
// - Power-down sends ones, drives shutdown low
// - Chip select high floats serial output
`timescale 1ns/10ps
`include "ascp_defines.svh"

module ascp_port
    import ascp_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      cs_n,
    input  wire logic                      sclk,
    input  wire logic                      din,
    output logic                           dout,
    output logic                           dout_oe,
    output logic                           system_shutdown_out_n,
    output logic                           conv_start,
    output ascp_conv_cfg_s                 conv_cfg,
    output logic                           sar_step,
    input  wire logic                      res_valid,
    output logic                           res_ready,
    input  wire logic [`ASCP_RES_BITS-1:0] res_data
);

    typedef struct packed {
        ascp_state_e                st;
        logic [`ASCP_CFG_BITS-1:0]  shift;
        logic [2:0]                 cfg_cnt;
        logic [4:0]                 seq_idx;
        ascp_cfg_s                  cfg;
        logic [`ASCP_RES_BITS-1:0]  word;
        logic                       have_word;
        logic                       null_sent;
        logic                       dout;
        logic                       dout_oe;
        logic                       shutdown_n;
        logic                       conv_start;
        logic                       sar_step;
        logic [3:0]                 step_cnt;
        ascp_conv_cfg_s             conv_cfg;
        logic                       buf_ready;
    } ascp_port_state_s;

    ascp_port_state_s              state;
    ascp_port_state_s              next_state;
    ascp_edges_s                   edges;
    logic                          buf_valid;
    logic [`ASCP_RES_BITS-1:0]     buf_data;
    logic                          buf_take;
    logic                          buf_flush;
    ascp_cfg_s                     cfg_word;
    logic                          take_word;

    // Channel decode shared by both multiplexer modes
    function automatic ascp_mux_s mux_decode(input ascp_cfg_s c);
        ascp_mux_s m;
        m.pos_channel   = {c.channel_index_hi, c.channel_index_lo, c.pair_polarity};
        m.neg_channel   = {c.channel_index_hi, c.channel_index_lo, ~c.pair_polarity};
        m.neg_is_common = c.single_ended_select;
        return m;
    endfunction

    // Output phase covers the null bits and the result
    function automatic logic in_output(input ascp_state_e s);
        logic r;
        r = 1'b0;
        case (s)
            ASCP_NULL: r = 1'b1;
            ASCP_DATA: r = 1'b1;
            default:   r = 1'b0;
        endcase
        return r;
    endfunction

    // Sequence index stops at the fill position
    function automatic logic [4:0] seq_next(input logic [4:0] idx);
        logic [4:0] n;
        n = idx;
        if (idx != `ASCP_SEQ_END) begin
            n = idx + 5'h01;
        end
        return n;
    endfunction

    // One converter step per clock fall, twelve at most
    function automatic logic step_due(input ascp_cfg_s c, input logic [3:0] cnt);
        return c.power_down_n && (cnt != `ASCP_SAR_STEPS);
    endfunction

    // Bit at a given position of the output sequence
    function automatic logic seq_bit(input logic [`ASCP_RES_BITS-1:0] w,
                                     input logic [4:0]                idx,
                                     input ascp_cfg_s                 c);
        logic [4:0] pos;
        logic       b;
        pos = 5'h00;
        b   = 1'b0;
        if (!c.power_down_n) begin
            b = (idx <= `ASCP_RES_LAST);
        end else if (idx <= `ASCP_RES_LAST) begin
            pos = `ASCP_RES_LAST - idx;
            b   = w[pos[3:0]];
        end else if (!c.bit_order_select && idx <= `ASCP_SEQ_LAST) begin
            pos = idx - `ASCP_RES_LAST;
            b   = w[pos[3:0]];
        end else if (!c.bit_order_select && !c.unipolar_select) begin
            b   = w[`ASCP_RES_BITS-1];
        end else begin
            b   = 1'b0;
        end
        return b;
    endfunction

    // Rises and falls seen one clock late
    ascp_edge u_edge (
        .core_clk (core_clk),
        .rstn     (rstn),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .din      (din),
        .edges    (edges)
    );

    // Stale results are dropped at every start and deselect
    assign buf_flush = state.conv_start | edges.cs_rise;
    assign buf_take  = state.buf_ready;
    assign take_word = state.buf_ready & buf_valid;

    // Two-entry result buffer
    ascp_buf u_buf (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .flush     (buf_flush),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (buf_valid),
        .out_ready (buf_take),
        .out_data  (buf_data)
    );

    // Config word as it stands on the seventh rise
    assign cfg_word = ascp_cfg_s'({state.shift[`ASCP_CFG_BITS-2:0], edges.din});

    // Next state of the whole port
    always_comb begin
        next_state            = state;
        next_state.conv_start = 1'b0;
        next_state.sar_step   = 1'b0;
        next_state.buf_ready  = 1'b0;

        // Capture the current conversion result once
        if (take_word) begin
            next_state.word      = buf_data;
            next_state.have_word = 1'b1;
        end
        if (in_output(state.st) && !state.have_word && !take_word &&
            state.cfg.power_down_n) begin
            next_state.buf_ready = 1'b1;
        end

        case (state.st)
            // Output off until the null bit
            ASCP_IDLE: begin
                next_state.dout_oe = 1'b0;
                if (edges.cs_fall || (edges.cs_low && !edges.cs_rise)) begin
                    next_state.st         = ASCP_HUNT;
                    next_state.shutdown_n = 1'b1;
                end
            end
            // Waits for the first one
            ASCP_HUNT: begin
                next_state.dout_oe = 1'b0;
                if (edges.sclk_rise && edges.din) begin
                    next_state.st      = ASCP_CFG;
                    next_state.cfg_cnt = 3'h0;
                    next_state.shift   = '0;
                end
            end
            // Seven bits, first bit most significant
            ASCP_CFG: begin
                next_state.dout_oe = 1'b0;
                if (edges.sclk_rise) begin
                    next_state.shift   = {state.shift[`ASCP_CFG_BITS-2:0], edges.din};
                    next_state.cfg_cnt = state.cfg_cnt + 3'h1;
                    if (state.cfg_cnt == `ASCP_CFG_LAST) begin
                        next_state.st                       = ASCP_NULL;
                        next_state.cfg                      = cfg_word;
                        next_state.conv_cfg.mux             = mux_decode(cfg_word);
                        next_state.conv_cfg.unipolar_select = cfg_word.unipolar_select;
                        next_state.conv_start               = cfg_word.power_down_n;
                        next_state.shutdown_n               = cfg_word.power_down_n;
                        next_state.have_word                = 1'b0;
                        next_state.null_sent                = 1'b0;
                        next_state.seq_idx                  = 5'h00;
                        next_state.step_cnt                 = 4'h0;
                    end
                end
            end
            // Null bits until the word is in
            ASCP_NULL: begin
                if (edges.sclk_fall) begin
                    next_state.dout_oe = 1'b1;
                    if (step_due(state.cfg, state.step_cnt)) begin
                        next_state.sar_step = 1'b1;
                        next_state.step_cnt = state.step_cnt + 4'h1;
                    end
                    if (state.null_sent && (state.have_word || !state.cfg.power_down_n)) begin
                        next_state.st      = ASCP_DATA;
                        next_state.dout    = seq_bit(state.word, 5'h00, state.cfg);
                        next_state.seq_idx = 5'h01;
                    end else begin
                        next_state.dout      = 1'b0;
                        next_state.null_sent = 1'b1;
                    end
                end
            end
            // One bit per clock fall
            ASCP_DATA: begin
                if (edges.sclk_fall) begin
                    next_state.dout = seq_bit(state.word, state.seq_idx, state.cfg);
                    next_state.seq_idx = seq_next(state.seq_idx);
                end
            end
            ASCP_SPARE: begin
                next_state.st = ASCP_IDLE;
            end
            default: begin
                next_state.st = ASCP_IDLE;
            end
        endcase

        // Input is not looked at past the config word
        if (in_output(state.st)) begin
            next_state.shift = state.shift;
        end

        // Deselect ends the exchange from any state
        if (edges.cs_rise) begin
            next_state.st        = ASCP_IDLE;
            next_state.dout_oe   = 1'b0;
            next_state.dout      = `ASCP_RST_DOUT;
            next_state.have_word = 1'b0;
            next_state.buf_ready = 1'b0;
            next_state.shift     = '0;
            next_state.cfg_cnt   = 3'h0;
            next_state.seq_idx   = 5'h00;
            next_state.null_sent = 1'b0;
            next_state.step_cnt  = 4'h0;
        end
    end

    // Serial state, reset to idle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state.st         <= ASCP_IDLE;
            state.shift      <= '0;
            state.cfg_cnt    <= 3'h0;
            state.seq_idx    <= 5'h00;
            state.cfg        <= ascp_cfg_s'(`ASCP_RST_CFG);
            state.word       <= '0;
            state.have_word  <= 1'b0;
            state.null_sent  <= 1'b0;
            state.dout       <= `ASCP_RST_DOUT;
            state.dout_oe    <= 1'b0;
            state.shutdown_n <= `ASCP_RST_SHUTDOWN_N;
            state.conv_start <= 1'b0;
            state.sar_step   <= 1'b0;
            state.step_cnt   <= 4'h0;
            state.conv_cfg   <= '0;
            state.buf_ready  <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign dout                  = state.dout;
    assign dout_oe               = state.dout_oe;
    assign system_shutdown_out_n = state.shutdown_n;
    assign conv_start            = state.conv_start;
    assign conv_cfg              = state.conv_cfg;
    assign sar_step              = state.sar_step;

endmodule // ascp_port

// [testbench/ascp_port_checker.sv]
`timescale 1ns/10ps
module ascp_port_checker
    import ascp_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           rstn,
    input wire logic           cs_n,
    input wire logic           sclk,
    input wire logic           din,
    input wire logic           dout,
    input wire logic           dout_oe,
    input wire logic           system_shutdown_out_n,
    input wire logic           conv_start,
    input wire ascp_conv_cfg_s conv_cfg,
    input wire logic           sar_step,
    input wire logic           res_valid,
    input wire logic           res_ready,
    input wire logic [11:0]    res_data
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence cs_release;
        $rose(cs_n);
    endsequence

    sequence null_bit;
        !dout && !sclk && !cs_n;
    endsequence

    oe_release_a: assert property (cs_release |-> ##[1:4] !dout_oe)
        else $error("dout_oe held after deselect");
    oe_idle_a: assert property (cs_n [*5] |-> !dout_oe)
        else $error("dout_oe on while deselected");
    start_first_a: assert property (conv_start |-> !dout_oe && system_shutdown_out_n)
        else $error("conversion started during output phase");
    step_fall_a: assert property (sar_step |-> !sclk && !cs_n)
        else $error("sar_step without clock fall");
    step_pace_a: assert property (sar_step |=> !sar_step [*8])
        else $error("sar_step faster than serial clock");
    dout_fall_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
        else $error("dout changed while clock high");
    oe_null_a: assert property ($rose(dout_oe) |-> null_bit)
        else $error("first output bit not a null");
    shutdown_quiet_a: assert property (!system_shutdown_out_n |-> !conv_start && !sar_step)
        else $error("conversion activity in shutdown");
    sso_release_a: assert property ($rose(system_shutdown_out_n) |-> !cs_n)
        else $error("shutdown released without select");
endmodule // ascp_port_checker

// [testbench/ascp_conv_model.sv]
`timescale 1ns/10ps
module ascp_conv_model
    import ascp_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rstn,
    input  wire logic           conv_start,
    input  wire logic           sar_step,
    input  wire ascp_conv_cfg_s conv_cfg,
    input  wire logic [1:0]     steps,
    input  wire logic           res_ready,
    output logic                res_valid,
    output logic [11:0]         res_data
);
    logic [1:0] cnt;
    logic       busy;

    // Result after a set number of steps, held until taken
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            cnt <= 2'h0;
            res_valid <= 1'b0;
            res_data <= 12'h000;
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt <= 2'h0;
            res_valid <= 1'b0;
        end else if (res_valid && res_ready) begin
            res_valid <= 1'b0;
        end else if (busy && sar_step) begin
            cnt <= cnt + 2'h1;
            if (cnt + 2'h1 == steps) begin
                busy <= 1'b0;
                res_valid <= 1'b1;
                res_data <= {conv_cfg, ~conv_cfg[3:0]};
            end
        end else if (!res_valid) begin
            res_data <= ~res_data;
        end
    end
endmodule // ascp_conv_model

// [testbench/ascp_port_tb.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ascp_port_tb;
    import ascp_pkg::*;
    logic           core_clk = 1'b0;
    logic           rstn     = 1'b0;
    logic           cs_n     = 1'b1;
    logic           sclk     = 1'b1;
    logic           host_d   = 1'b0;
    logic           tw       = 1'b0;
    logic [1:0]     steps    = 2'h1;
    logic           dout, dout_oe, sso_n, conv_start, sar_step, res_valid, res_ready;
    ascp_conv_cfg_s conv_cfg;
    logic [11:0]    res_data;
    logic [39:0]    seen;
    int             fail_count = 0;
    int             compares   = 0;
    int             starts     = 0;
    wire            din = (tw && dout_oe) ? dout : host_d;

    ascp_port u_ascp_port (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .dout_oe(dout_oe), .system_shutdown_out_n(sso_n),
        .conv_start(conv_start), .conv_cfg(conv_cfg), .sar_step(sar_step),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
    ascp_conv_model u_ascp_conv_model (.core_clk(core_clk), .rstn(rstn),
        .conv_start(conv_start), .sar_step(sar_step), .conv_cfg(conv_cfg), .steps(steps),
        .res_ready(res_ready), .res_valid(res_valid), .res_data(res_data));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (conv_start === 1'b1) starts++;
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One serial bit: drive on the fall, read dout late in the low phase
    task automatic bitclk(input logic d, output logic q);
        sclk <= 1'b0;
        host_d <= d;
        repeat (6) @(posedge core_clk);
        q = (dout_oe === 1'b1) ? dout : 1'bz;
        repeat (2) @(posedge core_clk);
        sclk <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic xact(input logic [6:0] cfg, input int lead, input int n);
        logic q;
        cs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < lead; i++) bitclk(1'b0, q);
        bitclk(1'b1, q);
        for (int i = 6; i >= 0; i--) bitclk(cfg[i], q);
        for (int i = 0; i < n; i++) begin
            bitclk(~i[0], q);
            seen[i] = q;
        end
        cs_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        `CHK("oe_off", 1'b0, dout_oe)
    endtask

    task automatic run(input logic [6:0] c, input int lead, input int k, input int n);
        ascp_conv_cfg_s ecfg;
        logic [11:0]    w;
        logic           b;
        int             n0;
        int             i;
        ecfg = {c[4], c[3], c[5], c[4], c[3], ~c[5], c[6], c[2]};
        w = {ecfg, ~ecfg[3:0]};
        n0 = starts;
        steps <= k[1:0];
        xact(c, lead, n);
        for (int j = 0; j < n; j++) begin
            i = j - k;
            if (i < 0) b = 1'b0;
            else if (!c[0]) b = (i < 12);
            else if (i < 12) b = w[11 - i];
            else if (c[1]) b = 1'b0;
            else if (i < 23) b = w[i - 11];
            else b = c[2] ? 1'b0 : w[11];
            `CHK("dout", b, seen[j])
        end
        `CHK("starts", n0 + c[0], starts)
        `CHK("sso_n", c[0], sso_n)
        if (c[0]) `CHK("cfg", ecfg, conv_cfg)
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        `CHK("oe_rst", 1'b0, dout_oe)
        `CHK("sso_rst", 1'b1, sso_n)
        `CHK("rdy_rst", 1'b1, res_ready)
        for (int m = 0; m < 16; m++) run({m[3:0], 3'b111}, m % 3, 1, 14);
        run(7'b0010001, 0, 1, 27);
        run(7'b1001101, 2, 1, 27);
        run(7'b0110110, 1, 1, 16);
        run(7'b0000111, 0, 1, 14);
        run(7'b1110111, 0, 3, 16);
        tw <= 1'b1;
        run(7'b0101011, 1, 1, 14);
        run(7'b1100111, 0, 1, 4);
        run(7'b0111111, 0, 1, 14);
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end
endmodule // ascp_port_tb

bind ascp_port ascp_port_checker u_ascp_port_checker (.core_clk(core_clk), .rstn(rstn),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .system_shutdown_out_n(system_shutdown_out_n), .conv_start(conv_start),
    .conv_cfg(conv_cfg), .sar_step(sar_step), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
